// [src/adc_serial_output_control.sv]
// Serial output configuration registers, control port, sample FIFO and lane serializer
//
// Overview of operation
// - Inversion bit set inverts every output bit.
// - Format bit defaults one; clear gives offset binary.
// - Two-bit field selects output termination resistor.
// - Termination codes: none, 200, 100, 100 ohms.
// - Drive bit doubles clock drivers only, default single.
// - Termination set overrides double clock drive.
// - Input clock delay field, zero to seven cycles.
// - Data clock phase code, 60 degree steps, default 180.
// - Default 0x30: 16-bit, two lanes, DDR, 4x.
// - 16-bit SDR or single lane runs 8x.
// - 12-bit DDR 3x; SDR or single lane 6x.
// - Bit 2 selects double frame, same multiplier.
// - Rate override applies only after transfer commit.
// - Other registers take effect when written.
// - Index register picks channels for later writes.
// - Pull-down bit set disconnects data pin pull-down.
// - Common-mode bit set powers down the generator.
`timescale 1ns/1ps

module sample_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gDepthCheck
    $error("sample_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module adc_serial_output_control #(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // System clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Serial control port
  input  wire logic       sclk,
  input  wire logic       csb_n,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe,
  // Sample stream
  input  wire logic [15:0] sampleData,
  input  wire logic       sampleValid,
  output logic            sampleReady,
  // Link side
  input  wire logic       linkClk,
  output logic            lane0_data,
  output logic            lane1_data,
  output logic            frame_clock_out,
  output logic            data_clock_out,
  // Analog and driver controls
  output logic [1:0]      termSelect,
  output logic            clkDriveDouble,
  output logic            narrowRange,
  output logic [2:0]      inputClockDelay,
  output logic [3:0]      dataClockPhase,
  output logic [3:0]      dataClockMult,
  output logic            rateOverrideEn,
  output logic [2:0]      rateOverrideCode,
  output logic            sdioPullDownEn,
  output logic            common_mode_output
);
  if (FIFO_DEPTH < 2) begin : gFifoCheck
    $error("adc_serial_output_control: FIFO_DEPTH too small");
  end

  // Control port synchronisers
  logic sclkS1_q, sclkS2_q, sclkPrev_q, csbS1_q, csbS2_q, sdioS1_q, sdioS2_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {sclkS1_q, sclkS2_q, sclkPrev_q} <= 3'h0;
      {csbS1_q, csbS2_q, sdioS1_q, sdioS2_q} <= 4'hC;
    end else begin
      sclkS1_q   <= sclk;
      sclkS2_q   <= sclkS1_q;
      sclkPrev_q <= sclkS2_q;
      csbS1_q    <= csb_n;
      csbS2_q    <= csbS1_q;
      sdioS1_q   <= sdioIn;
      sdioS2_q   <= sdioS1_q;
    end
  end
  logic sclkRise, sclkFall;
  assign sclkRise = sclkS2_q && !sclkPrev_q && !csbS2_q;
  assign sclkFall = !sclkS2_q && sclkPrev_q && !csbS2_q;

  // Control port framing: R/W, two spare bits, 13-bit address, 8 data bits
  logic [4:0]  bitCnt_q;
  logic [15:0] shift_q;
  logic        readOp_q;
  logic [12:0] addr_q;
  logic        regWrite;
  logic [7:0]  wData;
  logic [7:0]  readByte;
  assign regWrite = sclkRise && (bitCnt_q == adc_serial_pkg::SPI_ALL_BITS - 5'h1) && !readOp_q;
  assign wData    = {shift_q[6:0], sdioS2_q};
  always_ff @(posedge clk_sys) begin
    if (!rst_n || csbS2_q) begin
      bitCnt_q <= '0;
      shift_q  <= '0;
      readOp_q <= 1'b0;
      addr_q   <= '0;
    end else if (sclkRise && bitCnt_q != adc_serial_pkg::SPI_ALL_BITS) begin
      shift_q  <= {shift_q[14:0], sdioS2_q};
      bitCnt_q <= bitCnt_q + 5'h1;
      if (bitCnt_q == adc_serial_pkg::SPI_HDR_BITS - 5'h1) begin
        readOp_q <= shift_q[14];
        addr_q   <= {shift_q[11:0], sdioS2_q};
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || csbS2_q) begin
      sdioOut <= 1'b0;
      sdioOe  <= 1'b0;
    end else if (sclkFall && readOp_q && bitCnt_q >= adc_serial_pkg::SPI_HDR_BITS
                 && bitCnt_q < adc_serial_pkg::SPI_ALL_BITS) begin
      sdioOut <= readByte[3'(5'h7 - 5'(bitCnt_q - adc_serial_pkg::SPI_HDR_BITS))];
      sdioOe  <= 1'b1;
    end
  end

  // Configuration registers
  logic [7:0] index_q, mode_q, adjust_q, phase_q, sersel_q, rateStage_q, rateActive_q, pull_q, vcm_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      index_q     <= adc_serial_pkg::RST_INDEX;
      mode_q      <= adc_serial_pkg::RST_MODE;
      adjust_q    <= adc_serial_pkg::RST_ADJUST;
      phase_q     <= adc_serial_pkg::RST_PHASE;
      sersel_q    <= adc_serial_pkg::RST_SERSEL;
      rateStage_q <= adc_serial_pkg::RST_ZERO;
      pull_q      <= adc_serial_pkg::RST_ZERO;
      vcm_q       <= adc_serial_pkg::RST_ZERO;
    end else if (regWrite) begin
      case (addr_q)
        adc_serial_pkg::ADDR_INDEX:  index_q <= wData & adc_serial_pkg::MASK_INDEX;
        adc_serial_pkg::ADDR_MODE:   mode_q <= wData & adc_serial_pkg::MASK_MODE;
        adc_serial_pkg::ADDR_ADJUST: begin
          adjust_q[5:4] <= wData[5:4];
          if (index_q[adc_serial_pkg::IDX_CLKCH]) begin
            adjust_q[adc_serial_pkg::ADJ_DRIVE] <= wData[adc_serial_pkg::ADJ_DRIVE];
          end
        end
        adc_serial_pkg::ADDR_PHASE:  phase_q <= wData & adc_serial_pkg::MASK_PHASE;
        adc_serial_pkg::ADDR_SERSEL: sersel_q <= wData & adc_serial_pkg::MASK_SERSEL;
        adc_serial_pkg::ADDR_RATE:   rateStage_q <= wData & adc_serial_pkg::MASK_RATE;
        adc_serial_pkg::ADDR_PULL:   pull_q <= wData & adc_serial_pkg::MASK_PULL;
        adc_serial_pkg::ADDR_VCM:    vcm_q <= wData & adc_serial_pkg::MASK_VCM;
        default: ;
      endcase
    end
  end
  // Rate override only moves on a transfer commit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rateActive_q <= adc_serial_pkg::RST_ZERO;
    end else if (regWrite && addr_q == adc_serial_pkg::ADDR_TRANSFER && wData[adc_serial_pkg::XFER_BIT]) begin
      rateActive_q <= rateStage_q;
    end
  end
  always_comb begin
    case (addr_q)
      adc_serial_pkg::ADDR_INDEX:  readByte = index_q;
      adc_serial_pkg::ADDR_MODE:   readByte = mode_q;
      adc_serial_pkg::ADDR_ADJUST: readByte = adjust_q;
      adc_serial_pkg::ADDR_PHASE:  readByte = phase_q;
      adc_serial_pkg::ADDR_SERSEL: readByte = sersel_q;
      adc_serial_pkg::ADDR_RATE:   readByte = rateStage_q;
      adc_serial_pkg::ADDR_PULL:   readByte = pull_q;
      adc_serial_pkg::ADDR_VCM:    readByte = vcm_q;
      default:                     readByte = 8'h00;
    endcase
  end

  // Control outputs
  logic [2:0] serMode;
  logic       is12;
  assign serMode            = sersel_q[6:4];
  assign is12               = sersel_q[adc_serial_pkg::SER_WIDTH12];
  assign termSelect         = adjust_q[5:4];
  assign clkDriveDouble     = adjust_q[adc_serial_pkg::ADJ_DRIVE] && termSelect == adc_serial_pkg::TERM_NONE;
  assign narrowRange        = mode_q[adc_serial_pkg::MODE_NARROW];
  assign inputClockDelay    = phase_q[6:4];
  assign dataClockPhase     = phase_q[3:0];
  assign rateOverrideEn     = rateActive_q[adc_serial_pkg::RATE_EN];
  assign rateOverrideCode   = rateActive_q[2:0];
  assign sdioPullDownEn     = !pull_q[adc_serial_pkg::PULL_BIT];
  assign common_mode_output = !vcm_q[adc_serial_pkg::VCM_BIT];
  // Frame bit does not alter the multiplier
  always_comb begin
    dataClockMult = is12 ? adc_serial_pkg::MULT_DDR12 : adc_serial_pkg::MULT_DDR16;
    if (serMode == adc_serial_pkg::SMODE_SINGLE || !serMode[1]) begin
      dataClockMult = {dataClockMult[2:0], 1'b0};
    end
  end

  // Sample FIFO
  logic [15:0] fifoData;
  logic        fifoValid, fifoPop, busy;
  sample_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) sampleBuf (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inData  (sampleData),
    .inValid (sampleValid),
    .inReady (sampleReady),
    .outData (fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // Lane split: left-aligned bit order for each lane
  function automatic logic [31:0] buildLanes(input logic [15:0] w, input logic w12, input logic [2:0] m,
                                             input logic lsb);
    logic [15:0] v;
    logic [15:0] a;
    logic [15:0] b;
    int          n;
    v = '0;
    a = '0;
    b = '0;
    n = w12 ? 12 : 16;
    for (int j = 0; j < 16; j++) begin
      if (j < n) v[15-j] = lsb ? w[16-n+j] : w[15-j];
    end
    if (m == adc_serial_pkg::SMODE_SINGLE) begin
      a = v;
    end else if (m[0]) begin
      b = v;
      a = v << (n / 2);
    end else begin
      for (int k = 0; k < 8; k++) begin
        b[15-k] = v[15-2*k];
        a[15-k] = v[14-2*k];
      end
    end
    return {b, a};
  endfunction

  // Word handshake toward the link domain
  logic [15:0] fmtWord;
  logic [31:0] holdLanes_q;
  logic [4:0]  holdBits_q;
  logic        holdDouble_q, reqTgl_q, ackS1_q, ackS2_q, ackTgl_q;
  assign busy    = reqTgl_q != ackS2_q;
  assign fifoPop = fifoValid && !busy;
  always_comb begin
    fmtWord = fifoData;
    if (!mode_q[adc_serial_pkg::MODE_FMT]) fmtWord[15] = !fifoData[15];
    if (mode_q[adc_serial_pkg::MODE_INV]) fmtWord = ~fmtWord;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      holdLanes_q  <= '0;
      holdBits_q   <= '0;
      holdDouble_q <= 1'b0;
      reqTgl_q     <= 1'b0;
      ackS1_q      <= 1'b0;
      ackS2_q      <= 1'b0;
    end else begin
      ackS1_q <= ackTgl_q;
      ackS2_q <= ackS1_q;
      if (fifoPop) begin
        holdLanes_q  <= buildLanes(fmtWord, is12, serMode, sersel_q[adc_serial_pkg::SER_LSB]);
        holdBits_q   <= (serMode == adc_serial_pkg::SMODE_SINGLE) ? (is12 ? 5'hC : 5'h10) : (is12 ? 5'h6 : 5'h8);
        holdDouble_q <= sersel_q[adc_serial_pkg::SER_DFRAME];
        reqTgl_q     <= !reqTgl_q;
      end
    end
  end

  // Link domain serializer
  logic        lrS1_q, lrS2_q, reqS1_q, reqS2_q, frameTgl_q;
  logic [15:0] sh0_q, sh1_q;
  logic [4:0]  cnt_q, bits_q;
  logic        dbl_q, load;
  always_ff @(posedge linkClk) begin
    lrS1_q <= rst_n;
    lrS2_q <= lrS1_q;
  end
  assign load = (reqS2_q != ackTgl_q) && cnt_q == '0;
  always_ff @(posedge linkClk) begin
    if (!lrS2_q) begin
      {reqS1_q, reqS2_q, ackTgl_q, frameTgl_q, dbl_q} <= 5'h0;
      {sh0_q, sh1_q} <= '0;
      cnt_q  <= '0;
      bits_q <= '0;
      {lane0_data, lane1_data, frame_clock_out, data_clock_out} <= 4'h0;
    end else begin
      reqS1_q <= reqTgl_q;
      reqS2_q <= reqS1_q;
      if (load) begin
        ackTgl_q        <= reqS2_q;
        sh1_q           <= {holdLanes_q[30:16], 1'b0};
        sh0_q           <= {holdLanes_q[14:0], 1'b0};
        lane1_data      <= holdLanes_q[31];
        lane0_data      <= holdLanes_q[15];
        bits_q          <= holdBits_q;
        dbl_q           <= holdDouble_q;
        cnt_q           <= holdBits_q - 5'h1;
        frameTgl_q      <= !frameTgl_q;
        frame_clock_out <= holdDouble_q ? !frameTgl_q : 1'b1;
        data_clock_out  <= 1'b1;
      end else if (cnt_q != '0) begin
        sh1_q           <= {sh1_q[14:0], 1'b0};
        sh0_q           <= {sh0_q[14:0], 1'b0};
        lane1_data      <= sh1_q[15];
        lane0_data      <= sh0_q[15];
        cnt_q           <= cnt_q - 5'h1;
        frame_clock_out <= dbl_q ? frameTgl_q : ((bits_q - cnt_q) < (bits_q >> 1));
        data_clock_out  <= 1'b1;
      end else begin
        data_clock_out <= 1'b0;
      end
    end
  end

  // Checks
  a_reset_format: assert property (@(posedge clk_sys) !$past(rst_n) && rst_n |->
    mode_q == 8'h01 && phase_q == 8'h03) else $error("format or phase reset wrong");
  a_sersel_default: assert property (@(posedge clk_sys) !$past(rst_n) && rst_n |->
    sersel_q == 8'h30 && dataClockMult == 4'h4) else $error("default serialization wrong");
  a_drive_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_ADJUST && !index_q[5] |=> $stable(adjust_q[0]))
    else $error("drive bit changed without clock channel");
  a_term_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    termSelect != 2'h0 |-> !clkDriveDouble) else $error("double drive with termination");
  a_rate_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_RATE |=> $stable(rateActive_q)) else $error("rate moved early");
  a_rate_commit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_TRANSFER && wData[0] |=> rateActive_q == $past(rateStage_q))
    else $error("rate commit lost");
  a_mode_now: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_MODE |=> mode_q == ($past(wData) & 8'h45))
    else $error("mode write not immediate");
  a_mult_sixteen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !is12 && (serMode == 3'h4 || serMode[2:1] == 2'h0) |-> dataClockMult == 4'h8) else $error("16-bit 8x wrong");
  a_mult_twelve: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is12 && serMode[2:1] == 2'h1 |-> dataClockMult == 4'h3) else $error("12-bit 3x wrong");
  a_invert_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fifoPop && mode_q[2] && mode_q[0] && !is12 && serMode == 3'h3 && !sersel_q[7]
    |=> holdLanes_q[31:24] == ~$past(fifoData[15:8]) && holdLanes_q[15:8] == ~$past(fifoData[7:0]))
    else $error("inversion not applied");
  a_pull_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_PULL && wData[0] |=> !sdioPullDownEn) else $error("pull-down kept");
  a_vcm_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_VCM && wData[3] |=> !common_mode_output) else $error("vcm kept");
  c_rate_commit: cover property (@(posedge clk_sys) disable iff (!rst_n)
    regWrite && addr_q == adc_serial_pkg::ADDR_TRANSFER);
  c_reg_read: cover property (@(posedge clk_sys) disable iff (!rst_n) sdioOe && readOp_q);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_n) sampleValid && !sampleReady);
  c_word_sent: cover property (@(posedge linkClk) disable iff (!lrS2_q) load ##1 data_clock_out [*4]);
endmodule

// [src/adc_serial_pkg.sv]
// Register map, field positions and reset values of the serial output control block
package adc_serial_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] ADDR_INDEX    = 13'h0005;
  localparam logic [12:0] ADDR_MODE     = 13'h0014;
  localparam logic [12:0] ADDR_ADJUST   = 13'h0015;
  localparam logic [12:0] ADDR_PHASE    = 13'h0016;
  localparam logic [12:0] ADDR_SERSEL   = 13'h0021;
  localparam logic [12:0] ADDR_TRANSFER = 13'h00FF;
  localparam logic [12:0] ADDR_RATE     = 13'h0100;
  localparam logic [12:0] ADDR_PULL     = 13'h0101;
  localparam logic [12:0] ADDR_VCM      = 13'h0102;
  // Reset values
  localparam logic [7:0] RST_INDEX  = 8'h2F;
  localparam logic [7:0] RST_MODE   = 8'h01;
  localparam logic [7:0] RST_ADJUST = 8'h00;
  localparam logic [7:0] RST_PHASE  = 8'h03;
  localparam logic [7:0] RST_SERSEL = 8'h30;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  // Writable bit masks
  localparam logic [7:0] MASK_INDEX  = 8'h2F;
  localparam logic [7:0] MASK_MODE   = 8'h45;
  localparam logic [7:0] MASK_ADJUST = 8'h31;
  localparam logic [7:0] MASK_PHASE  = 8'h7F;
  localparam logic [7:0] MASK_SERSEL = 8'hF7;
  localparam logic [7:0] MASK_RATE   = 8'h47;
  localparam logic [7:0] MASK_PULL   = 8'h01;
  localparam logic [7:0] MASK_VCM    = 8'h08;
  // Field positions
  localparam int unsigned IDX_CLKCH   = 5;
  localparam int unsigned MODE_FMT    = 0;
  localparam int unsigned MODE_INV    = 2;
  localparam int unsigned MODE_NARROW = 6;
  localparam int unsigned ADJ_DRIVE   = 0;
  localparam int unsigned ADJ_TERM_LO = 4;
  localparam int unsigned PH_ICLK_LO  = 4;
  localparam int unsigned SER_WIDTH12 = 1;
  localparam int unsigned SER_DFRAME  = 2;
  localparam int unsigned SER_MODE_LO = 4;
  localparam int unsigned SER_LSB     = 7;
  localparam int unsigned RATE_EN     = 6;
  localparam int unsigned XFER_BIT    = 0;
  localparam int unsigned PULL_BIT    = 0;
  localparam int unsigned VCM_BIT     = 3;
  // Termination codes
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_200  = 2'h1;
  // Serial data modes
  localparam logic [2:0] SMODE_SINGLE = 3'h4;
  // Data clock multipliers
  localparam logic [3:0] MULT_DDR16 = 4'h4;
  localparam logic [3:0] MULT_DDR12 = 4'h3;
  // Control port framing
  localparam logic [4:0] SPI_HDR_BITS = 5'h10;
  localparam logic [4:0] SPI_ALL_BITS = 5'h18;
endpackage

// [tb/lane_capture_model.sv]
// Receiver model that captures byte-wise dual-lane words from the link
`timescale 1ns/1ps
module lane_capture_model (
  // Link side
  input  wire logic        linkClk,
  input  wire logic        lane0_data,
  input  wire logic        lane1_data,
  input  wire logic        frame_clock_out,
  input  wire logic        data_clock_out,
  // Capture results
  output logic      [15:0] rxWord,
  output int               rxCount,
  output int               frameErrs
);
  logic [7:0] hiByte = 8'h00;
  logic [7:0] loByte = 8'h00;
  int         bitCnt = 0;
  initial begin
    rxWord = 16'h0000;
    rxCount = 0;
    frameErrs = 0;
  end
  // Lane 1 carries the upper byte, lane 0 the lower, MSB first
  always @(posedge linkClk) begin
    if (data_clock_out === 1'b1) begin
      if (frame_clock_out !== ((bitCnt < 4) ? 1'b1 : 1'b0)) frameErrs++;
      hiByte = {hiByte[6:0], lane1_data};
      loByte = {loByte[6:0], lane0_data};
      bitCnt++;
      if (bitCnt == 8) begin
        rxWord = {hiByte, loByte};
        rxCount++;
        bitCnt = 0;
      end
    end else begin
      bitCnt = 0;
    end
  end
endmodule

// [tb/tb_adc_serial_output_control.sv]
// Testbench for the serial output control block
`timescale 1ns/1ps
module tb_adc_serial_output_control;
  logic        clk_sys = 1'b0;
  logic        linkClk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclk = 1'b0;
  logic        csb_n = 1'b1;
  logic        sdioIn = 1'b0;
  logic [15:0] sampleData = 16'h0000;
  logic        sampleValid = 1'b0;
  logic        sdioOut, sdioOe, sampleReady, lane0_data, lane1_data, frame_clock_out, data_clock_out;
  logic [1:0]  termSelect;
  logic        clkDriveDouble, narrowRange, rateOverrideEn, sdioPullDownEn, common_mode_output;
  logic [2:0]  inputClockDelay, rateOverrideCode;
  logic [3:0]  dataClockPhase, dataClockMult;
  logic [15:0] rxWord;
  int          rxCount, frameErrs;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [7:0]  rd;
  logic        rdOe;
  logic [7:0]  codes [10] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h34, 8'h40, 8'h32, 8'h12, 8'h42, 8'h06};
  logic [3:0]  mults [10] = '{4'h4, 4'h4, 4'h8, 4'h8, 4'h4, 4'h8, 4'h3, 4'h6, 4'h6, 4'h6};
  logic [7:0]  modes [3] = '{8'h01, 8'h05, 8'h00};
  logic [15:0] wexp [3] = '{16'h1234, 16'hEDCB, 16'h9234};

  always #20 clk_sys = ~clk_sys;
  always #62.5 linkClk = ~linkClk;

  adc_serial_output_control dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csb_n(csb_n), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .linkClk(linkClk), .lane0_data(lane0_data), .lane1_data(lane1_data),
    .frame_clock_out(frame_clock_out), .data_clock_out(data_clock_out), .termSelect(termSelect),
    .clkDriveDouble(clkDriveDouble), .narrowRange(narrowRange), .inputClockDelay(inputClockDelay),
    .dataClockPhase(dataClockPhase), .dataClockMult(dataClockMult), .rateOverrideEn(rateOverrideEn),
    .rateOverrideCode(rateOverrideCode), .sdioPullDownEn(sdioPullDownEn),
    .common_mode_output(common_mode_output));

  lane_capture_model rx_u (
    .linkClk(linkClk), .lane0_data(lane0_data), .lane1_data(lane1_data),
    .frame_clock_out(frame_clock_out), .data_clock_out(data_clock_out),
    .rxWord(rxWord), .rxCount(rxCount), .frameErrs(frameErrs));

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One 24-bit control frame; read data is caught after falls 16 to 23
  task automatic spi(input logic rdFlag, input logic [12:0] addr, input logic [7:0] wdat);
    logic [23:0] fr;
    fr = {rdFlag, 2'b00, addr, wdat};
    @(posedge clk_sys) csb_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys) sdioIn <= fr[23-i];
      repeat (5) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (6) @(posedge clk_sys);
      if (i >= 15 && i < 23) rd[22-i] = sdioOut;
      if (i == 15) rdOe = sdioOe;
    end
    @(posedge clk_sys) csb_n <= 1'b1;
    sdioIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask

  task automatic rdchk(input string name, input logic [12:0] a, input logic [7:0] exp);
    spi(1'b1, a, 8'h00);
    chk(name, 16'(exp), 16'(rd));
    chk("sdioOe", 16'h0001, 16'(rdOe));
    chk("sdioOeOff", 16'h0000, 16'(sdioOe));
  endtask

  // Push one sample, wait for it at the receiver and compare
  task automatic sendWord(input logic [15:0] d, input logic [15:0] exp);
    int c;
    c = rxCount;
    @(posedge clk_sys) sampleData <= d;
    sampleValid <= 1'b1;
    @(negedge clk_sys);
    @(posedge clk_sys) sampleValid <= 1'b0;
    for (int k = 0; k < 300 && rxCount == c; k++) @(posedge clk_sys);
    chk("rxCount", 16'(c + 1), 16'(rxCount));
    chk("rxWord", exp, rxWord);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    int n;
    int base;
    logic full;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk("mode", adc_serial_pkg::ADDR_MODE, 8'h01);
    rdchk("adjust", adc_serial_pkg::ADDR_ADJUST, 8'h00);
    rdchk("phase", adc_serial_pkg::ADDR_PHASE, 8'h03);
    rdchk("sersel", adc_serial_pkg::ADDR_SERSEL, 8'h30);
    rdchk("transfer", adc_serial_pkg::ADDR_TRANSFER, 8'h00);
    chk("mult", 16'h0004, 16'(dataClockMult));
    chk("drive", 16'h0000, 16'(clkDriveDouble));
    chk("pullDown", 16'h0001, 16'(sdioPullDownEn));
    chk("vcm", 16'h0001, 16'(common_mode_output));
    for (int i = 0; i < 10; i++) begin
      wr(adc_serial_pkg::ADDR_SERSEL, codes[i]);
      chk("mult", 16'(mults[i]), 16'(dataClockMult));
    end
    wr(adc_serial_pkg::ADDR_SERSEL, 8'h30);
    for (int t = 0; t < 4; t++) begin
      wr(adc_serial_pkg::ADDR_ADJUST, {2'b00, 2'(t), 4'h1});
      chk("term", 16'(t), 16'(termSelect));
      chk("drive", (t == 0) ? 16'h0001 : 16'h0000, 16'(clkDriveDouble));
    end
    wr(adc_serial_pkg::ADDR_ADJUST, 8'h00);
    wr(adc_serial_pkg::ADDR_INDEX, 8'h0F);
    wr(adc_serial_pkg::ADDR_ADJUST, 8'h01);
    chk("drive", 16'h0000, 16'(clkDriveDouble));
    wr(adc_serial_pkg::ADDR_INDEX, 8'h2F);
    wr(adc_serial_pkg::ADDR_PHASE, 8'h7B);
    chk("iclkDelay", 16'h0007, 16'(inputClockDelay));
    chk("dclkPhase", 16'h000B, 16'(dataClockPhase));
    wr(adc_serial_pkg::ADDR_RATE, 8'h45);
    chk("rateEn", 16'h0000, 16'(rateOverrideEn));
    wr(adc_serial_pkg::ADDR_TRANSFER, 8'h01);
    chk("rateEn", 16'h0001, 16'(rateOverrideEn));
    chk("rateCode", 16'h0005, 16'(rateOverrideCode));
    rdchk("rate", adc_serial_pkg::ADDR_RATE, 8'h45);
    wr(adc_serial_pkg::ADDR_PULL, 8'h01);
    chk("pullDown", 16'h0000, 16'(sdioPullDownEn));
    wr(adc_serial_pkg::ADDR_VCM, 8'h08);
    chk("vcm", 16'h0000, 16'(common_mode_output));
    wr(13'h0030, 8'hFF);
    rdchk("unmapped", 13'h0030, 8'h00);
    wr(adc_serial_pkg::ADDR_MODE, 8'h40);
    chk("narrow", 16'h0001, 16'(narrowRange));
    for (int m = 0; m < 3; m++) begin
      wr(adc_serial_pkg::ADDR_MODE, modes[m]);
      sendWord(16'h1234, wexp[m]);
    end
    wr(adc_serial_pkg::ADDR_SERSEL, 8'hB0);
    sendWord(16'h1234, 16'h2C49);
    wr(adc_serial_pkg::ADDR_SERSEL, 8'h30);
    // Fill the sample queue until it refuses, then let the link drain it
    base = rxCount;
    n = 0;
    full = 1'b0;
    @(posedge clk_sys) sampleData <= 16'hA55A;
    sampleValid <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      if (sampleReady === 1'b1) n++;
      else full = 1'b1;
    end
    @(posedge clk_sys) sampleValid <= 1'b0;
    chk("refused", 16'h0001, 16'(full));
    for (int k = 0; k < 4000 && rxCount < base + n; k++) @(posedge clk_sys);
    chk("drained", 16'(n), 16'(rxCount - base));
    chk("lastWord", 16'h255A, rxWord);
    chk("frameErrs", 16'h0000, 16'(frameErrs));
    test_done();
  end
endmodule
